// file: chk_cnt_pkg.sv
// Shared constants for the checker counters and generator gap block
package chk_cnt_pkg;
  // Register bus widths
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  // Register offsets
  localparam logic [15:0] GAP_CFG_OFF = 16'h061b;
  localparam logic [15:0] BYTE_TOT_OFF = 16'h061c;
  localparam logic [15:0] PKT_LO_OFF = 16'h061d;
  localparam logic [15:0] PKT_HI_OFF = 16'h061e;
  localparam logic [15:0] STAT_OFF = 16'h0620;
  localparam logic [15:0] IRQ_STAT_OFF = 16'h0630;
  localparam logic [15:0] IRQ_MASK_OFF = 16'h0631;
  localparam logic [15:0] MODE_OFF = 16'h0632;
  // Counter and field widths
  localparam int GAP_W = 8;
  localparam int BYTE_W = 16;
  localparam int PKT_W = 32;
  localparam int ERR_W = 8;
  localparam int EV_W = 3;
  // Reset values
  localparam logic [7:0] GAP_RST = 8'h7d;
  localparam logic [2:0] MASK_RST = 3'h0;
  localparam logic MODE_RST = 1'b0;
  // Status word bits; a write of SNAP or CLR snapshots the counters, CLR also clears them
  localparam int SNAP_BIT = 0;
  localparam int CLR_BIT = 1;
  localparam int LOCK_BIT = 8;
  localparam int BYTE_OV_BIT = 9;
  localparam int PKT_OV_BIT = 10;
  localparam int BUSY_BIT = 11;
  localparam int DONE_BIT = 12;
  // Mode register bit: 0 single, 1 continuous
  localparam int MODE_BIT = 0;
  // Interrupt event bits
  localparam int EV_BYTE = 0;
  localparam int EV_PKT = 1;
  localparam int EV_LOCK = 2;
endpackage

// file: sat_wrap_counter.sv
// Event counter that saturates in single mode and wraps in continuous mode
`timescale 1ns/1ps
`default_nettype none
module sat_wrap_counter #(
  parameter int W = 16
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic inc_i,
  input wire logic clear_i,
  input wire logic cont_mode_i,
  output logic [W-1:0] count_o,
  output logic hit_o
);
  typedef struct packed {
    logic [W-1:0] count;
  } cnt_state_t;

  cnt_state_t state;
  cnt_state_t next_state;

  // An increment that meets the top value
  assign hit_o = inc_i && (state.count == {W{1'b1}});
  assign count_o = state.count;

  // Clear beats increment; top value either holds or rolls to zero
  always_comb
  begin
    next_state = state;
    if (clear_i)
    begin
      next_state.count = '0;
    end
    else if (hit_o)
    begin
      if (cont_mode_i)
      begin
        next_state.count = '0;
      end
    end
    else if (inc_i)
    begin
      next_state.count = state.count + 1'b1;
    end
  end

  // State register, frozen while ce_i is low
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      state <= '0;
    end
    else if (ce_i)
    begin
      state <= next_state;
    end
  end

  a_top_holds: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    ce_i && hit_o && !cont_mode_i && !clear_i |=> count_o == {W{1'b1}})
    else $error("single mode counter left its top value");
endmodule
`default_nettype wire

// file: ipg_timer.sv
// Inter-packet gap timer for the packet generator
`timescale 1ns/1ps
`default_nettype none
module ipg_timer (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic [7:0] gap_len_i,
  input wire logic pkt_end_i,
  input wire logic byte_tick_i,
  output logic gap_active_o
);
  typedef struct packed {
    logic [7:0] remain;
  } gap_state_t;

  gap_state_t state;
  gap_state_t next_state;

  // Generator must hold off while bytes of gap remain
  assign gap_active_o = (state.remain != 8'h00);

  // Load at packet end, count down one per byte time
  always_comb
  begin
    next_state = state;
    if (pkt_end_i)
    begin
      next_state.remain = gap_len_i;
    end
    else if (byte_tick_i && gap_active_o)
    begin
      next_state.remain = state.remain - 8'h01;
    end
  end

  // State register, frozen while ce_i is low
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      state <= '0;
    end
    else if (ce_i)
    begin
      state <= next_state;
    end
  end

  a_gap_load: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    ce_i && pkt_end_i |=> state.remain == $past(gap_len_i))
    else $error("gap length not loaded at packet end");
endmodule
`default_nettype wire

// file: chk_counter_top.sv
// Checker byte and packet counters with snapshot, status word and gap setting
`timescale 1ns/1ps
`default_nettype none
module chk_counter_top (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic [15:0] addr_i,
  input wire logic [15:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rd_data_o,
  input wire logic byte_rx_i,
  input wire logic pkt_rx_i,
  input wire logic bit_err_i,
  input wire logic lock_i,
  input wire logic pkt_done_i,
  input wire logic gen_busy_i,
  input wire logic gen_pkt_end_i,
  input wire logic gen_byte_tick_i,
  output logic gap_active_o,
  output logic wrap_pulse_o,
  output logic irq_o
);
  typedef struct packed {
    logic [7:0] gap_len;
    logic cnt_mode;
    logic [15:0] byte_snap;
    logic [31:0] pkt_snap;
    logic [7:0] err_snap;
    logic byte_ov;
    logic pkt_ov;
    logic lock_prev;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic [15:0] rd_data;
    logic wrap_pulse;
  } top_state_t;

  top_state_t state;
  top_state_t next_state;

  logic [15:0] byte_live;
  logic [31:0] pkt_live;
  logic [7:0] err_live;
  logic byte_hit;
  logic pkt_hit;
  logic err_hit;
  logic stat_wr;
  logic snap_wr;
  logic clr_wr;
  logic [2:0] events;

  // Address match for a write or read strobe
  function automatic logic reg_hit(input logic strobe, input logic [15:0] a,
                                   input logic [15:0] off);
    reg_hit = strobe && (a == off);
  endfunction

  // Status word writes: bit 0 snapshots, bit 1 snapshots and clears
  assign stat_wr = reg_hit(wr_i, addr_i, chk_cnt_pkg::STAT_OFF);
  assign snap_wr = stat_wr && (wr_data_i[chk_cnt_pkg::SNAP_BIT] ||
                               wr_data_i[chk_cnt_pkg::CLR_BIT]);
  assign clr_wr = stat_wr && wr_data_i[chk_cnt_pkg::CLR_BIT];

  // Received byte counter
  sat_wrap_counter #(.W(chk_cnt_pkg::BYTE_W)) u_byte_cnt (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .inc_i(byte_rx_i),
    .clear_i(clr_wr),
    .cont_mode_i(state.cnt_mode),
    .count_o(byte_live),
    .hit_o(byte_hit)
  );

  // Received packet counter
  sat_wrap_counter #(.W(chk_cnt_pkg::PKT_W)) u_pkt_cnt (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .inc_i(pkt_rx_i),
    .clear_i(clr_wr),
    .cont_mode_i(state.cnt_mode),
    .count_o(pkt_live),
    .hit_o(pkt_hit)
  );

  // Errored bit counter
  sat_wrap_counter #(.W(chk_cnt_pkg::ERR_W)) u_err_cnt (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .inc_i(bit_err_i),
    .clear_i(clr_wr),
    .cont_mode_i(state.cnt_mode),
    .count_o(err_live),
    .hit_o(err_hit)
  );

  // Generator gap timer
  ipg_timer u_gap (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .gap_len_i(state.gap_len),
    .pkt_end_i(gen_pkt_end_i),
    .byte_tick_i(gen_byte_tick_i),
    .gap_active_o(gap_active_o)
  );

  // Interrupt sources: byte and packet counter overflows and loss of lock
  always_comb
  begin
    events = '0;
    events[chk_cnt_pkg::EV_BYTE] = byte_hit;
    events[chk_cnt_pkg::EV_PKT] = pkt_hit;
    events[chk_cnt_pkg::EV_LOCK] = state.lock_prev && !lock_i;
  end

  // Next state: config writes, snapshots, flags, read data
  always_comb
  begin
    next_state = state;
    next_state.lock_prev = lock_i;
    next_state.rd_data = '0;
    next_state.wrap_pulse = state.cnt_mode && !clr_wr &&
                            (byte_hit || pkt_hit || err_hit);
    if (reg_hit(wr_i, addr_i, chk_cnt_pkg::GAP_CFG_OFF))
    begin
      next_state.gap_len = wr_data_i[7:0];
    end
    if (reg_hit(wr_i, addr_i, chk_cnt_pkg::MODE_OFF))
    begin
      next_state.cnt_mode = wr_data_i[chk_cnt_pkg::MODE_BIT];
    end
    if (reg_hit(wr_i, addr_i, chk_cnt_pkg::IRQ_MASK_OFF))
    begin
      next_state.irq_mask = wr_data_i[2:0];
    end
    // Snapshot takes the live counts before any clear lands
    if (snap_wr)
    begin
      next_state.byte_snap = byte_live;
      next_state.pkt_snap = pkt_live;
      next_state.err_snap = err_live;
    end
    // Overflow flags: clear only by the clearing write, set wins
    if (clr_wr)
    begin
      next_state.byte_ov = 1'b0;
      next_state.pkt_ov = 1'b0;
    end
    if (byte_hit)
    begin
      next_state.byte_ov = 1'b1;
    end
    if (pkt_hit)
    begin
      next_state.pkt_ov = 1'b1;
    end
    // Register reads; unmapped addresses return zero
    if (rd_i)
    begin
      case (addr_i)
        chk_cnt_pkg::GAP_CFG_OFF: next_state.rd_data = {8'h00, state.gap_len};
        chk_cnt_pkg::BYTE_TOT_OFF: next_state.rd_data = state.byte_snap;
        chk_cnt_pkg::PKT_LO_OFF: next_state.rd_data = state.pkt_snap[15:0];
        chk_cnt_pkg::PKT_HI_OFF: next_state.rd_data = state.pkt_snap[31:16];
        chk_cnt_pkg::STAT_OFF:
        begin
          next_state.rd_data[chk_cnt_pkg::DONE_BIT] = pkt_done_i;
          next_state.rd_data[chk_cnt_pkg::BUSY_BIT] = gen_busy_i;
          next_state.rd_data[chk_cnt_pkg::PKT_OV_BIT] = state.pkt_ov;
          next_state.rd_data[chk_cnt_pkg::BYTE_OV_BIT] = state.byte_ov;
          next_state.rd_data[chk_cnt_pkg::LOCK_BIT] = lock_i;
          next_state.rd_data[7:0] = state.err_snap;
        end
        chk_cnt_pkg::IRQ_STAT_OFF: next_state.rd_data = {13'h0000, state.irq_stat};
        chk_cnt_pkg::IRQ_MASK_OFF: next_state.rd_data = {13'h0000, state.irq_mask};
        chk_cnt_pkg::MODE_OFF: next_state.rd_data = {15'h0000, state.cnt_mode};
        default: next_state.rd_data = '0;
      endcase
    end
    // Sticky events clear on a status read; a new event still lands
    if (reg_hit(rd_i, addr_i, chk_cnt_pkg::IRQ_STAT_OFF))
    begin
      next_state.irq_stat = events;
    end
    else
    begin
      next_state.irq_stat = state.irq_stat | events;
    end
  end

  // State register, frozen while ce_i is low
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      state <= '0;
      state.gap_len <= chk_cnt_pkg::GAP_RST;
      state.cnt_mode <= chk_cnt_pkg::MODE_RST;
      state.irq_mask <= chk_cnt_pkg::MASK_RST;
    end
    else if (ce_i)
    begin
      state <= next_state;
    end
  end

  // Outputs
  assign rd_data_o = state.rd_data;
  assign wrap_pulse_o = state.wrap_pulse;
  assign irq_o = |(state.irq_stat & state.irq_mask);

  // Checks
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (sys_rst_i);

  sequence s_clear_write;
    ce_i && clr_wr;
  endsequence

  sequence s_counts_zero;
    byte_live == 16'h0000 && pkt_live == 32'h0000_0000 && err_live == 8'h00;
  endsequence

  a_gap_reset: assert property ($fell(sys_rst_i) |-> state.gap_len == chk_cnt_pkg::GAP_RST)
    else $error("gap length not 7d after reset");

  a_byte_count: assert property (ce_i && byte_rx_i && !clr_wr &&
    byte_live != 16'hffff |=> byte_live == $past(byte_live) + 16'h0001)
    else $error("byte count did not advance");

  a_snap_take: assert property (ce_i && snap_wr |=>
    state.byte_snap == $past(byte_live) && state.pkt_snap == $past(pkt_live))
    else $error("snapshot missed the live counts");

  a_byte_sat: assert property (ce_i && !state.cnt_mode && !clr_wr &&
    byte_live == 16'hffff |=> byte_live == 16'hffff)
    else $error("byte count left its top in single mode");

  a_pkt_count: assert property (ce_i && pkt_rx_i && !clr_wr &&
    pkt_live != 32'hffff_ffff |=> pkt_live == $past(pkt_live) + 32'h0000_0001)
    else $error("packet count did not advance");

  a_pkt_sat: assert property (ce_i && !state.cnt_mode && !clr_wr &&
    pkt_live == 32'hffff_ffff |=> pkt_live == 32'hffff_ffff)
    else $error("packet count left its top in single mode");

  a_clear_all: assert property (s_clear_write |=> s_counts_zero)
    else $error("clearing write left a count");

  a_snap_only: assert property (ce_i && snap_wr && !clr_wr &&
    byte_live != 16'hffff |=> byte_live >= $past(byte_live))
    else $error("snapshot-only write disturbed the byte count");

  a_ov_hold: assert property (state.byte_ov && !(ce_i && clr_wr) |=>
    state.byte_ov)
    else $error("byte overflow flag dropped without clear");

  a_wrap_pulse: assert property (ce_i && state.cnt_mode && byte_hit &&
    !clr_wr |=> byte_live == 16'h0000 && wrap_pulse_o)
    else $error("continuous wrap missing pulse or restart");

  a_lock_read: assert property (ce_i && reg_hit(rd_i, addr_i,
    chk_cnt_pkg::STAT_OFF) |=> rd_data_o[chk_cnt_pkg::LOCK_BIT] == $past(lock_i))
    else $error("lock bit does not follow lock input");

  a_snap_stable: assert property (ce_i && !snap_wr |=>
    $stable(state.byte_snap) && $stable(state.pkt_snap))
    else $error("snapshot moved without a snapshot write");

  a_gap_write: assert property (ce_i && reg_hit(wr_i, addr_i,
    chk_cnt_pkg::GAP_CFG_OFF) |=> state.gap_len == $past(wr_data_i[7:0]))
    else $error("gap length write did not land");

  a_byte_ov_set: assert property (ce_i && byte_hit |=> state.byte_ov)
    else $error("byte overflow flag not set on overflow");

  a_pkt_ov_set: assert property (ce_i && pkt_hit |=> state.pkt_ov)
    else $error("packet overflow flag not set on overflow");

  a_ov_clear: assert property (ce_i && clr_wr && !byte_hit |=> !state.byte_ov)
    else $error("clearing write left the byte overflow flag");

  a_rd_idle: assert property (ce_i && !rd_i |=> rd_data_o == 16'h0000)
    else $error("read data present without a read");
endmodule
`default_nettype wire

// file: test_chk_counter_top.sv
// Self-checking testbench for the checker counters, snapshot, status word and gap timer
`timescale 1ns/1ps
`default_nettype none
module test_chk_counter_top;
  logic mclk_i;
  logic sys_rst_i;
  logic ce_i;
  logic [15:0] addr_i;
  logic [15:0] wr_data_i;
  logic wr_i;
  logic rd_i;
  logic [15:0] rd_data_o;
  logic [2:0] ev;
  logic lock_i;
  logic pkt_done_i;
  logic gen_busy_i;
  logic gen_pkt_end_i;
  logic gen_byte_tick_i;
  logic gap_active_o;
  logic wrap_pulse_o;
  logic irq_o;
  int n_mismatch;
  int comparisons;

  chk_counter_top i_dut (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .addr_i(addr_i),
    .wr_data_i(wr_data_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rd_data_o(rd_data_o),
    .byte_rx_i(ev[0]),
    .pkt_rx_i(ev[1]),
    .bit_err_i(ev[2]),
    .lock_i(lock_i),
    .pkt_done_i(pkt_done_i),
    .gen_busy_i(gen_busy_i),
    .gen_pkt_end_i(gen_pkt_end_i),
    .gen_byte_tick_i(gen_byte_tick_i),
    .gap_active_o(gap_active_o),
    .wrap_pulse_o(wrap_pulse_o),
    .irq_o(irq_o)
  );

  // Free-running 100 MHz clock
  initial
  begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  // Verdict and end of run
  task automatic end_of_test();
    if (n_mismatch == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Compare one value and report a difference
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One-cycle register write, then one idle edge before the next strobe
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    addr_i <= a;
    wr_data_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    @(posedge mclk_i);
  endtask

  // One-cycle read, data sampled in the following cycle
  task automatic rc(input string what, input logic [15:0] a, input logic [15:0] exp);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    @(negedge mclk_i);
    chk(what, rd_data_o, exp);
    @(posedge mclk_i);
  endtask

  // Hold one event input high for n edges
  task automatic burst(input int idx, input int n);
    ev[idx] <= 1'b1;
    repeat (n) @(posedge mclk_i);
    ev[idx] <= 1'b0;
    @(posedge mclk_i);
  endtask

  // Watchdog against a hang
  initial
  begin
    repeat (90000) @(posedge mclk_i);
    n_mismatch++;
    end_of_test();
  end

  // Main sequence
  initial
  begin
    n_mismatch = 0;
    comparisons = 0;
    sys_rst_i = 1'b1;
    ce_i = 1'b1;
    addr_i = 16'h0000;
    wr_data_i = 16'h0000;
    wr_i = 1'b0;
    rd_i = 1'b0;
    ev = 3'h0;
    lock_i = 1'b0;
    pkt_done_i = 1'b0;
    gen_busy_i = 1'b0;
    gen_pkt_end_i = 1'b0;
    gen_byte_tick_i = 1'b0;
    repeat (3) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    // Reset values
    rc("gap", chk_cnt_pkg::GAP_CFG_OFF, 16'h007d);
    rc("bytes", chk_cnt_pkg::BYTE_TOT_OFF, 16'h0000);
    rc("pkt_lo", chk_cnt_pkg::PKT_LO_OFF, 16'h0000);
    rc("pkt_hi", chk_cnt_pkg::PKT_HI_OFF, 16'h0000);
    rc("status", chk_cnt_pkg::STAT_OFF, 16'h0000);
    rc("unmapped", 16'h0625, 16'h0000);
    // Gap field width and gap timing
    wr(chk_cnt_pkg::GAP_CFG_OFF, 16'h1234);
    rc("gap", chk_cnt_pkg::GAP_CFG_OFF, 16'h0034);
    wr(chk_cnt_pkg::GAP_CFG_OFF, 16'h0002);
    gen_pkt_end_i <= 1'b1;
    @(posedge mclk_i);
    gen_pkt_end_i <= 1'b0;
    gen_byte_tick_i <= 1'b1;
    @(negedge mclk_i);
    chk("gap_active", gap_active_o, 16'h0001);
    @(posedge mclk_i);
    @(negedge mclk_i);
    chk("gap_active", gap_active_o, 16'h0001);
    @(posedge mclk_i);
    gen_byte_tick_i <= 1'b0;
    @(negedge mclk_i);
    chk("gap_active", gap_active_o, 16'h0000);
    @(posedge mclk_i);
    // Frozen clock enable: strobes and counts are lost
    ce_i <= 1'b0;
    wr(chk_cnt_pkg::GAP_CFG_OFF, 16'h0055);
    burst(0, 4);
    ce_i <= 1'b1;
    rc("gap", chk_cnt_pkg::GAP_CFG_OFF, 16'h0002);
    // Snapshot holds while live counts move on
    burst(0, 5);
    burst(1, 3);
    wr(chk_cnt_pkg::STAT_OFF, 16'h0001);
    burst(0, 3);
    rc("bytes", chk_cnt_pkg::BYTE_TOT_OFF, 16'h0005);
    rc("pkt_lo", chk_cnt_pkg::PKT_LO_OFF, 16'h0003);
    rc("pkt_hi", chk_cnt_pkg::PKT_HI_OFF, 16'h0000);
    rc("bytes", chk_cnt_pkg::BYTE_TOT_OFF, 16'h0005);
    // Clearing write snapshots first, then zeroes the counters
    wr(chk_cnt_pkg::STAT_OFF, 16'h0002);
    rc("bytes", chk_cnt_pkg::BYTE_TOT_OFF, 16'h0008);
    wr(chk_cnt_pkg::STAT_OFF, 16'h0001);
    rc("bytes", chk_cnt_pkg::BYTE_TOT_OFF, 16'h0000);
    rc("pkt_lo", chk_cnt_pkg::PKT_LO_OFF, 16'h0000);
    // Lock, busy and done indications
    lock_i <= 1'b1;
    pkt_done_i <= 1'b1;
    gen_busy_i <= 1'b1;
    @(posedge mclk_i);
    rc("status", chk_cnt_pkg::STAT_OFF, 16'h1900);
    lock_i <= 1'b0;
    pkt_done_i <= 1'b0;
    gen_busy_i <= 1'b0;
    @(posedge mclk_i);
    rc("status", chk_cnt_pkg::STAT_OFF, 16'h0000);
    rc("irq_stat", chk_cnt_pkg::IRQ_STAT_OFF, 16'h0004);
    rc("irq_stat", chk_cnt_pkg::IRQ_STAT_OFF, 16'h0000);
    // Error count stops at its top in single mode
    burst(2, 300);
    wr(chk_cnt_pkg::STAT_OFF, 16'h0001);
    rc("status", chk_cnt_pkg::STAT_OFF, 16'h00ff);
    wr(chk_cnt_pkg::STAT_OFF, 16'h0002);
    // Continuous mode wraps with a pulse
    wr(chk_cnt_pkg::MODE_OFF, 16'h0001);
    burst(2, 255);
    ev[2] <= 1'b1;
    @(posedge mclk_i);
    ev[2] <= 1'b0;
    @(negedge mclk_i);
    chk("wrap_pulse", wrap_pulse_o, 16'h0001);
    @(posedge mclk_i);
    wr(chk_cnt_pkg::STAT_OFF, 16'h0001);
    rc("status", chk_cnt_pkg::STAT_OFF, 16'h0000);
    wr(chk_cnt_pkg::MODE_OFF, 16'h0000);
    // Byte count saturation, overflow flag and masked interrupt
    burst(0, 65537);
    @(negedge mclk_i);
    chk("irq", irq_o, 16'h0000);
    @(posedge mclk_i);
    wr(chk_cnt_pkg::STAT_OFF, 16'h0001);
    rc("bytes", chk_cnt_pkg::BYTE_TOT_OFF, 16'hffff);
    rc("status", chk_cnt_pkg::STAT_OFF, 16'h0200);
    wr(chk_cnt_pkg::IRQ_MASK_OFF, 16'h0001);
    @(negedge mclk_i);
    chk("irq", irq_o, 16'h0001);
    @(posedge mclk_i);
    rc("irq_mask", chk_cnt_pkg::IRQ_MASK_OFF, 16'h0001);
    rc("irq_stat", chk_cnt_pkg::IRQ_STAT_OFF, 16'h0001);
    @(negedge mclk_i);
    chk("irq", irq_o, 16'h0000);
    @(posedge mclk_i);
    wr(chk_cnt_pkg::STAT_OFF, 16'h0001);
    rc("status", chk_cnt_pkg::STAT_OFF, 16'h0200);
    // Continuous mode at the top value wraps the byte count with a pulse
    wr(chk_cnt_pkg::MODE_OFF, 16'h0001);
    rc("mode", chk_cnt_pkg::MODE_OFF, 16'h0001);
    ev[0] <= 1'b1;
    @(posedge mclk_i);
    ev[0] <= 1'b0;
    @(negedge mclk_i);
    chk("wrap_pulse", wrap_pulse_o, 16'h0001);
    chk("irq", irq_o, 16'h0001);
    @(posedge mclk_i);
    @(negedge mclk_i);
    chk("wrap_pulse", wrap_pulse_o, 16'h0000);
    @(posedge mclk_i);
    wr(chk_cnt_pkg::STAT_OFF, 16'h0001);
    rc("bytes", chk_cnt_pkg::BYTE_TOT_OFF, 16'h0000);
    rc("status", chk_cnt_pkg::STAT_OFF, 16'h0200);
    wr(chk_cnt_pkg::MODE_OFF, 16'h0000);
    wr(chk_cnt_pkg::STAT_OFF, 16'h0002);
    rc("status", chk_cnt_pkg::STAT_OFF, 16'h0000);
    // Mid-run reset restores the setup values
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    @(negedge mclk_i);
    chk("irq", irq_o, 16'h0000);
    @(posedge mclk_i);
    rc("gap", chk_cnt_pkg::GAP_CFG_OFF, 16'h007d);
    rc("mode", chk_cnt_pkg::MODE_OFF, 16'h0000);
    end_of_test();
  end
endmodule
`default_nettype wire
